// ===== inc/supervisor_pkg.sv
package supervisor_pkg;
  // ==========================================
  // time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 17;
  // ==========================================
  // watchdog and reset timing, in ms ticks
  localparam int WATCHDOG_PERIOD_MS = 1600;
  localparam int RESET_HOLD_MS = 200;
  localparam int RESET_HOLD_MIN_MS = 140;
  localparam int RESET_HOLD_MAX_MS = 280;
  localparam int WD_W = 11;
  localparam int RS_W = 9;
  localparam logic [WD_W-1:0] WD_LAST = WD_W'(WATCHDOG_PERIOD_MS - 1);
  localparam logic [RS_W-1:0] RS_LAST = RS_W'(RESET_HOLD_MS - 1);
  // ==========================================
  // synchroniser lanes
  localparam int SYNC_W = 6;
  localparam int LANE_SUPPLY = 0;
  localparam int LANE_KICK = 1;
  localparam int LANE_DRIVEN = 2;
  localparam int LANE_PFI = 3;
  localparam int LANE_BATT_HI = 4;
  localparam int LANE_MAIN_HI = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h00;
  // ==========================================
  // reset sequencer states
  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_STRETCH = 3'h2,
    ST_RUN = 3'h4
  } rst_state_t;
endpackage

// ===== verilog/reset_watchdog_supervisor.sv
module reset_watchdog_supervisor
  import supervisor_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic supply_ok_in,
  input wire logic watchdog_kick_input_in,
  input wire logic watchdog_kick_driven_in,
  input wire logic powerfail_sense_input_in,
  input wire logic backup_above_main_in,
  input wire logic main_above_backup_in,
  output logic reset_n_out,
  output logic reset_out,
  output logic powerfail_flag_output_out,
  output logic backed_supply_output_backup_out
);
  // ==========================================
  // input synchronisers
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic [SYNC_W-1:0] raw_in;
  logic kick_prev_reg;
  logic supply_s;
  logic kick_s;
  logic driven_s;
  logic pfi_s;
  logic batt_hi_s;
  logic main_hi_s;
  logic kick_edge;
  assign raw_in = {main_above_backup_in, backup_above_main_in, powerfail_sense_input_in,
                   watchdog_kick_driven_in, watchdog_kick_input_in, supply_ok_in};
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
      kick_prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      kick_prev_reg <= sync_reg[LANE_KICK];
    end
  end
  assign supply_s = sync_reg[LANE_SUPPLY];
  assign kick_s = sync_reg[LANE_KICK];
  assign driven_s = sync_reg[LANE_DRIVEN];
  assign pfi_s = sync_reg[LANE_PFI];
  assign batt_hi_s = sync_reg[LANE_BATT_HI];
  assign main_hi_s = sync_reg[LANE_MAIN_HI];
  // a 50 ns pulse spans at least two 20 ns edges, so it survives the sampler
  assign kick_edge = kick_s ^ kick_prev_reg;

  // ==========================================
  // millisecond prescaler
  logic [PRESCALE_W-1:0] pre_reg;
  logic [PRESCALE_W-1:0] pre_next;
  logic tick;
  always_comb
  begin
    tick = (pre_reg == PRESCALE_W'(TICK_LEN - 1));
    pre_next = tick ? '0 : pre_reg + 1'b1;
  end
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pre_reg <= '0;
    else
      pre_reg <= pre_next;
  end
  // ==========================================
  // watchdog
  // free-running prescaler means up to one tick of slack, well inside tolerance
  rst_state_t state_reg;
  rst_state_t state_next;
  logic [WD_W-1:0] wd_reg;
  logic [WD_W-1:0] wd_next;
  logic wd_fire;
  always_comb
  begin
    wd_fire = 1'b0;
    wd_next = wd_reg;
    if (state_reg != ST_RUN || !driven_s || kick_edge)
      wd_next = '0;
    else if (tick)
    begin
      if (wd_reg == WD_LAST)
      begin
        wd_fire = 1'b1;
        wd_next = '0;
      end
      else
        wd_next = wd_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wd_reg <= '0;
    else
      wd_reg <= wd_next;
  end
  // ==========================================
  // reset sequencer
  logic [RS_W-1:0] rs_reg;
  logic [RS_W-1:0] rs_next;
  logic rst_n_reg;
  logic rst_reg;
  always_comb
  begin
    state_next = state_reg;
    rs_next = rs_reg;
    case (state_reg)
      ST_HOLD:
      begin
        rs_next = '0;
        if (supply_s)
          state_next = ST_STRETCH;
      end
      ST_STRETCH:
      begin
        if (!supply_s)
        begin
          state_next = ST_HOLD;
          rs_next = '0;
        end
        else if (tick)
        begin
          if (rs_reg == RS_LAST)
          begin
            state_next = ST_RUN;
            rs_next = '0;
          end
          else
            rs_next = rs_reg + 1'b1;
        end
      end
      ST_RUN:
      begin
        rs_next = '0;
        if (!supply_s)
          state_next = ST_HOLD;
        else if (wd_fire)
          state_next = ST_STRETCH;
      end
      default:
      begin
        state_next = ST_HOLD;
        rs_next = '0;
      end
    endcase
  end
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg <= ST_HOLD;
      rs_reg <= '0;
      rst_n_reg <= 1'b0;
      rst_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      rs_reg <= rs_next;
      rst_n_reg <= (state_next == ST_RUN);
      rst_reg <= (state_next != ST_RUN);
    end
  end
  // ==========================================
  // backup switchover and power-fail flag
  logic backup_reg;
  logic backup_next;
  logic pf_reg;
  logic pf_next;
  always_comb
  begin
    backup_next = backup_reg;
    if (supply_s)
      backup_next = 1'b0;
    else if (!backup_reg && batt_hi_s)
      backup_next = 1'b1;
    else if (backup_reg && main_hi_s)
      backup_next = 1'b0;
    // comparator is off on backup, saving battery current
    pf_next = pfi_s && !backup_next;
  end
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      backup_reg <= 1'b0;
      pf_reg <= 1'b0;
    end
    else
    begin
      backup_reg <= backup_next;
      pf_reg <= pf_next;
    end
  end
  assign reset_n_out = rst_n_reg;
  assign reset_out = rst_reg;
  assign powerfail_flag_output_out = pf_reg;
  assign backed_supply_output_backup_out = backup_reg;
  // ==========================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_wd_expire;
    state_reg == ST_RUN && driven_s && !kick_edge && tick && wd_reg == WD_LAST;
  endsequence
  sequence s_stretch_restart;
    state_reg == ST_HOLD && rs_reg == '0;
  endsequence
  property p_wd_timeout;
    (s_wd_expire and supply_s) |=> state_reg == ST_STRETCH ##0 !reset_n_out;
  endproperty
  a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog expiry missed");
  property p_undriven_quiet;
    !driven_s |-> !wd_fire;
  endproperty
  a_undriven_quiet: assert property (p_undriven_quiet) else $error("timeout while undriven");
  property p_edge_clears;
    kick_edge |=> wd_reg == '0;
  endproperty
  a_edge_clears: assert property (p_edge_clears) else $error("kick edge did not clear");
  property p_held_zero;
    (!reset_n_out || !driven_s) |=> wd_reg == '0;
  endproperty
  a_held_zero: assert property (p_held_zero) else $error("watchdog counted in reset");
  property p_counts;
    state_reg == ST_RUN && driven_s && !kick_edge && tick && wd_reg != WD_LAST
      |=> wd_reg == $past(wd_reg) + 1'b1;
  endproperty
  a_counts: assert property (p_counts) else $error("watchdog did not advance");
  property p_pulse_len;
    $rose(reset_n_out) |-> $past(rs_reg) == RS_LAST && $past(tick);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset released early");
  property p_supply_low;
    !supply_s |=> !reset_n_out;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("reset high on low supply");
  property p_dip_restart;
    state_reg == ST_STRETCH && !supply_s |=> s_stretch_restart;
  endproperty
  a_dip_restart: assert property (p_dip_restart) else $error("dip did not restart");
  property p_inverse;
    reset_out == !reset_n_out;
  endproperty
  a_inverse: assert property (p_inverse) else $error("reset outputs not inverse");
  property p_pf_follow;
    !backup_reg |-> powerfail_flag_output_out == $past(pfi_s);
  endproperty
  a_pf_follow: assert property (p_pf_follow) else $error("power-fail flag wrong");
  property p_pf_backup;
    backup_reg |-> !powerfail_flag_output_out;
  endproperty
  a_pf_backup: assert property (p_pf_backup) else $error("flag high on backup");
  property p_main_ok;
    supply_s |=> !backed_supply_output_backup_out;
  endproperty
  a_main_ok: assert property (p_main_ok) else $error("backup used with good supply");
  property p_to_backup;
    !supply_s && batt_hi_s && !backup_reg |=> backed_supply_output_backup_out;
  endproperty
  a_to_backup: assert property (p_to_backup) else $error("no switch to backup");
  property p_sync;
    // first two edges after release still show the flops' reset contents
    $past(arst_n_in, 2) |-> sync_reg == $past(raw_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("inputs not two-stage synced");
endmodule

// ===== testbench/cpu_model.sv
module cpu_model
#(
  parameter int KICK_GAP = 3000
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic kick_en_in,
  input wire logic float_en_in,
  output logic kick_out,
  output logic driven_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // kick generator
  int gap = 0;
  logic held = 1'b0;
  always @(negedge clk_in)
  begin
    gap = (kick_en_in && reset_n_in && gap < KICK_GAP) ? gap + 1 : 0;
    driven_out <= !float_en_in;
    // released line rests opposite its last level: no edges, so only driven can stop a timeout
    if (float_en_in)
      kick_out <= !held;
    else
    begin
      held <= kick_en_in && gap > KICK_GAP - 3;
      kick_out <= kick_en_in && gap > KICK_GAP - 3;
    end
  end
endmodule

// ===== testbench/test_reset_watchdog_supervisor.sv
module test_reset_watchdog_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import supervisor_pkg::*;
  // ==========================================
  // setup
  localparam int TICK = 4;
  localparam int WD = WATCHDOG_PERIOD_MS * TICK;
  localparam int RS = RESET_HOLD_MS * TICK;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic supply_ok = 1'b0;
  logic sense = 1'b1;
  logic batt_hi = 1'b0;
  logic main_hi = 1'b0;
  logic kick_en = 1'b0;
  logic float_en = 1'b0;
  logic kick, driven, reset_n, reset, pf, backup;
  int mismatches = 0;
  int comparisons = 0;
  always #10 clk_in = !clk_in;
  reset_watchdog_supervisor #(.TICK_LEN(TICK)) reset_watchdog_supervisor_inst (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .supply_ok_in(supply_ok),
    .watchdog_kick_input_in(kick),
    .watchdog_kick_driven_in(driven),
    .powerfail_sense_input_in(sense),
    .backup_above_main_in(batt_hi),
    .main_above_backup_in(main_hi),
    .reset_n_out(reset_n),
    .reset_out(reset),
    .powerfail_flag_output_out(pf),
    .backed_supply_output_backup_out(backup)
  );
  cpu_model cpu_model_inst (
    .clk_in(clk_in),
    .reset_n_in(reset_n),
    .kick_en_in(kick_en),
    .float_en_in(float_en),
    .kick_out(kick),
    .driven_out(driven)
  );
  // ==========================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_rst(input logic exp);
    check("reset_n_out", exp, reset_n);
    check("reset_out", !exp, reset);
  endtask
  // bounded wait, tolerance covers sync delay and tick phase
  task automatic wait_rst(input logic exp, input int max);
    int n;
    n = 0;
    while (reset_n !== exp && n < max)
    begin
      cyc(1);
      n++;
    end
    chk_rst(exp);
  endtask
  task automatic close_out();
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic power_up();
    cyc(10);
    chk_rst(1'b0);
    supply_ok = 1'b1;
    cyc(RS - 20);
    chk_rst(1'b0);
    wait_rst(1'b1, 40);
  endtask
  task automatic brownout_restart();
    supply_ok = 1'b0;
    wait_rst(1'b0, 6);
    supply_ok = 1'b1;
    cyc(RS / 2);
    supply_ok = 1'b0;
    cyc(2);
    supply_ok = 1'b1;
    cyc(RS - 20);
    chk_rst(1'b0);
    wait_rst(1'b1, 40);
  endtask
  task automatic stuck_kick();
    cyc(WD - 40);
    chk_rst(1'b1);
    wait_rst(1'b0, 60);
    cyc(RS - 20);
    chk_rst(1'b0);
    wait_rst(1'b1, 40);
  endtask
  task automatic serviced();
    kick_en = 1'b1;
    cyc(WD + 400);
    chk_rst(1'b1);
    cyc(WD - 400);
    chk_rst(1'b1);
    kick_en = 1'b0;
  endtask
  task automatic floating();
    float_en = 1'b1;
    cyc(WD + 400);
    chk_rst(1'b1);
    cyc(WD - 400);
    chk_rst(1'b1);
    float_en = 1'b0;
    cyc(WD - 40);
    chk_rst(1'b1);
    wait_rst(1'b0, 60);
    wait_rst(1'b1, RS + 40);
  endtask
  task automatic async_reset();
    cyc(20);
    arst_n_in = 1'b0;
    cyc(2);
    chk_rst(1'b0);
    check("powerfail_flag", 1'b0, pf);
    check("backup_select", 1'b0, backup);
    arst_n_in = 1'b1;
    cyc(RS - 20);
    chk_rst(1'b0);
    wait_rst(1'b1, 40);
    check("powerfail_flag", 1'b1, pf);
  endtask
  task automatic power_fail();
    sense = 1'b0;
    cyc(4);
    check("powerfail_flag", 1'b0, pf);
    sense = 1'b1;
    cyc(4);
    check("powerfail_flag", 1'b1, pf);
    supply_ok = 1'b0;
    batt_hi = 1'b1;
    cyc(4);
    check("backup_select", 1'b1, backup);
    check("powerfail_flag", 1'b0, pf);
    batt_hi = 1'b0;
    cyc(4);
    check("backup_select", 1'b1, backup);
    main_hi = 1'b1;
    cyc(4);
    check("backup_select", 1'b0, backup);
    check("powerfail_flag", 1'b1, pf);
    main_hi = 1'b0;
    batt_hi = 1'b1;
    cyc(4);
    check("backup_select", 1'b1, backup);
    check("powerfail_flag", 1'b0, pf);
    supply_ok = 1'b1;
    cyc(4);
    check("backup_select", 1'b0, backup);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial
  begin
    cyc(6);
    arst_n_in = 1'b1;
    power_up();
    brownout_restart();
    stuck_kick();
    serviced();
    floating();
    async_reset();
    power_fail();
    close_out();
  end
  initial
  begin
    // roughly twice the expected run length
    #(90000 * 20);
    mismatches++;
    close_out();
  end
endmodule
